// ===== hdl/sfp_pkg.sv
/*
  constants and carrier types for the serial flash pin front end.
  assumes one system clock; all pins already synchronous to it.
*/
// Operation
// - with the dedicated reset high the part runs, with it low the part is held in reset and every output floats.
// - the dedicated reset input is ignored when bit 0 of the function configuration register is one.
// - with quad off and dedicated reset disabled, the fourth pin is pause when the select bit is 0 and reset when it is 1.
// - command, address and data bits are sampled on rising serial clock edges.
// - each output bit is launched at a falling serial clock edge.
// - in dual operation the input and output pins become bidirectional data lines 0 and 1.
// - in quad or quad command mode the input, output, write-protect and pause pins become data lines 0 to 3.
// - with chip enable high the part is deselected, floats its outputs and takes no input.
// - with pause low and chip enable low the output floats and the transfer is frozen until pause returns high.
package sfp_pkg;

  // lane width modes
  localparam logic [1:0] SFP_WIDTH_SINGLE = 2'h0;
  localparam logic [1:0] SFP_WIDTH_DUAL   = 2'h1;
  localparam logic [1:0] SFP_WIDTH_QUAD   = 2'h2;

  localparam int SFP_FUNC_RESET_DIS_BIT = 0;
  localparam logic [3:0] SFP_LANES_OFF  = 4'hF;

  // lane masks and pin positions
  localparam int         SFP_LANE_COUNT   = 4;
  localparam int         SFP_PIN4_LANE    = 3;
  localparam logic [3:0] SFP_MASK_SINGLE  = 4'h1;
  localparam logic [3:0] SFP_MASK_SO      = 4'h2;
  localparam logic [3:0] SFP_MASK_DUAL    = 4'h3;
  localparam logic [3:0] SFP_MASK_NO_PIN4 = 4'h7;
  localparam logic [3:0] SFP_MASK_QUAD    = 4'hF;

  typedef enum logic [2:0] {
    SFP_ST_RESET = 3'h1,
    SFP_ST_IDLE  = 3'h2,
    SFP_ST_ACT   = 3'h4
  } sfp_state_t;

  // per-lane pin pair: oe_n low while the device drives
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe_n;
  } sfp_pins_out_t;

  // core side mode controls
  typedef struct packed {
    logic [1:0] width;
    logic       quad_enable_bit;
    logic       pause_or_reset_select_bit;
    logic [7:0] func_cfg;
  } sfp_cfg_t;

endpackage : sfp_pkg

// ===== hdl/sfp_port.sv
/*
  serial flash pin front end: reset and pause selection, edge detection of
  the host serial clock, bit sampling and launching over 1, 2 or 4 lanes.
  assumes sck, ce_n and data pins are already synchronous to clk and that
  clk runs well above the serial clock; the core feeds mode controls.
  sck edges must be at least two clk cycles apart, so double data rate
  transfers are not served here; the core owns commands and byte assembly.
*/
`timescale 1ns/100ps
module sfp_port
  import sfp_pkg::*;
(
  // system
  input  wire logic       clk,
  input  wire logic       reset,
  // host pins
  input  wire logic       sck,
  input  wire logic       ce_n,
  input  wire logic       reset_n,
  input  wire logic [3:0] data_line_in,
  output logic      [3:0] data_line_out,
  output logic      [3:0] data_line_oe_n,
  // core side
  input  wire sfp_cfg_t   cfg,
  input  wire logic       core_drive,
  input  wire logic [3:0] core_tx,
  output logic      [3:0] rx_bits,
  output logic            rx_valid,
  output logic            tx_take,
  output logic            in_reset,
  output logic            paused,
  output logic            selected
);

  // serial clock edge tracking
  logic       sck_q;
  logic       rise;
  logic       fall;
  // selection and pin roles
  sfp_state_t state;
  logic       armed;
  logic       dedicated_reset;
  logic       pin4_reset;
  logic       hold_fn;
  logic       rst_active;
  logic       pause_n;
  // lane control
  logic [3:0] lane_mask;
  logic [3:0] tx_mask;
  logic [3:0] tx_bits;
  logic       rx_ok;
  logic       tx_block;

  // the pin vectors and the lane map must agree
  if ($bits(data_line_in) != SFP_LANE_COUNT) begin : g_lane_check
    $error("sfp_port: pin vectors do not match the lane count");
  end

  // lanes that carry data for a width code; used for receive, and for transmit except in single width
  function automatic logic [3:0] lanes_of(input logic [1:0] w);
    case (w)
      SFP_WIDTH_DUAL: lanes_of = SFP_MASK_DUAL;
      SFP_WIDTH_QUAD: lanes_of = SFP_MASK_QUAD;
      default:        lanes_of = SFP_MASK_SINGLE;
    endcase
  endfunction : lanes_of

  // single width listens on line 0 but answers on line 1
  function automatic logic [3:0] answer_lanes_of(input logic [1:0] w, input logic [3:0] mask);
    if (w == SFP_WIDTH_SINGLE) begin
      answer_lanes_of = SFP_MASK_SO;
    end else begin
      answer_lanes_of = mask;
    end
  endfunction : answer_lanes_of

  // fourth pin role: data in quad, otherwise pause, or reset only when the
  // dedicated reset is switched off and the select bit asks for it
  always_comb begin
    dedicated_reset = !cfg.func_cfg[SFP_FUNC_RESET_DIS_BIT];
    pin4_reset      = !cfg.quad_enable_bit && !dedicated_reset
                      && cfg.pause_or_reset_select_bit;
    hold_fn         = !cfg.quad_enable_bit && !pin4_reset;
    rst_active      = (dedicated_reset && !reset_n)
                      || (pin4_reset && !data_line_in[SFP_PIN4_LANE]);
    pause_n         = !(hold_fn && !data_line_in[SFP_PIN4_LANE] && !ce_n);
  end

  // pin 4 stays a control pin unless quad operation is switched on
  always_comb begin
    lane_mask = lanes_of(cfg.width);
    if (!cfg.quad_enable_bit) begin
      lane_mask = lane_mask & SFP_MASK_NO_PIN4;
    end
    tx_mask = answer_lanes_of(cfg.width, lane_mask);
    if (cfg.width == SFP_WIDTH_SINGLE) begin
      tx_bits = SFP_MASK_SO & {SFP_LANE_COUNT{core_tx[0]}};
    end else begin
      tx_bits = core_tx & lane_mask;
    end
  end

  always_comb begin
    rise = !sck_q && sck;
    fall = sck_q && !sck;
  end

  // a transfer moves only while selected, out of reset and not paused;
  // the core picks the direction with core_drive
  always_comb begin
    rx_ok    = (state == SFP_ST_ACT) && !ce_n && pause_n && !rst_active && !core_drive;
    tx_block = rst_active || ce_n || !pause_n || (state != SFP_ST_ACT) || !core_drive;
  end

  // no reset here: the flop follows the pin, so an idle-high clock in
  // mode 3 gives no false rising edge on the first cycle after reset
  always_ff @(posedge clk) begin
    sck_q <= sck;
  end

  // selection counts only after ce_n has been seen high since any reset
  always_ff @(posedge clk) begin
    if (reset || rst_active) begin
      armed <= 1'b0;
    end else if (ce_n) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= SFP_ST_RESET;
    end else if (rst_active) begin
      state <= SFP_ST_RESET;
    end else begin
      case (state)
        SFP_ST_RESET: begin
          if (ce_n) begin
            state <= SFP_ST_IDLE;
          end
        end
        SFP_ST_IDLE: begin
          if (!ce_n && armed) begin
            state <= SFP_ST_ACT;
          end
        end
        SFP_ST_ACT: begin
          if (ce_n) begin
            state <= SFP_ST_IDLE;
          end
        end
        default: begin
          state <= SFP_ST_RESET;
        end
      endcase
    end
  end

  // receive on rising edges; a pause freezes the sequence rather than reset it
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_bits <= 4'h0;
    end else if (rx_ok && rise) begin
      rx_bits <= data_line_in & lane_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= rx_ok && rise;
    end
  end

  // launch on falling edges; a driven lane holds its bit until the next fall
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_take <= 1'b0;
    end else begin
      tx_take <= !tx_block && fall;
    end
  end

  // one flop pair per lane; a lane outside the mask is released
  for (genvar lane = 0; lane < SFP_LANE_COUNT; lane++) begin : g_lane
    always_ff @(posedge clk) begin
      if (reset) begin
        data_line_out[lane]  <= 1'b0;
        data_line_oe_n[lane] <= SFP_LANES_OFF[lane];
      end else if (tx_block) begin
        data_line_oe_n[lane] <= SFP_LANES_OFF[lane];
      end else if (fall) begin
        data_line_out[lane]  <= tx_bits[lane];
        data_line_oe_n[lane] <= !tx_mask[lane];
      end
    end
  end

  // status levels for the core, one cycle behind the pins; selected rises two cycles after ce_n falls
  always_ff @(posedge clk) begin
    if (reset) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= rst_active;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      paused <= 1'b0;
    end else begin
      paused <= !pause_n;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      selected <= 1'b0;
    end else begin
      selected <= (state == SFP_ST_ACT) && !ce_n;
    end
  end

endmodule : sfp_port

// ===== tb/sfp_monitor.sv
/* pin checker for sfp_port; bound below, one clock, sync reset */
`timescale 1ns/100ps
module sfp_monitor
  import sfp_pkg::*;
(
  input wire logic       clk, reset, sck, ce_n, reset_n, core_drive,
  input wire logic       rx_valid, tx_take, in_reset, paused, selected,
  input wire logic [3:0] data_line_in, data_line_oe_n,
  input wire sfp_cfg_t   cfg
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rise; !sck ##1 sck; endsequence
  a_rst_float: assert property (in_reset [*2] |-> &data_line_oe_n)
    else $error("oe");
  a_rst_pin: assert property (!reset_n && !cfg.func_cfg[0] |=> in_reset)
    else $error("reset");
  a_rst_off: assert property ((cfg.func_cfg[0] && !cfg.pause_or_reset_select_bit) [*2]
    |-> !in_reset) else $error("ignore");
  a_pin4_rst: assert property (!cfg.quad_enable_bit && cfg.func_cfg[0]
    && cfg.pause_or_reset_select_bit && !data_line_in[3] |=> in_reset) else $error("pin");
  a_off_float: assert property (ce_n [*3] |-> &data_line_oe_n && !rx_valid)
    else $error("off");
  a_hold_float: assert property (paused [*2] |-> &data_line_oe_n)
    else $error("pause");
  a_rise_rx: assert property (s_rise ##0 (selected && !paused && !core_drive)
    |=> rx_valid) else $error("rx");
  a_fall_tx: assert property (tx_take |-> !$past(sck) && $past(sck, 2))
    else $error("tx");
endmodule : sfp_monitor
bind sfp_port sfp_monitor sfp_monitor_inst (.*);

// ===== tb/sfp_host.sv
/* host model: mode 0 clock, select, reset pin, lane drive; called at clk falls */
`timescale 1ns/100ps
module sfp_host (
  input  wire logic       clk,
  input  wire logic [3:0] data_line_out, data_line_oe_n,
  output logic            sck, ce_n, reset_n,
  output logic [3:0]      data_line_in
);
  logic [3:0] drive = 4'hF;
  assign data_line_in = data_line_oe_n & drive | ~data_line_oe_n & data_line_out;
  initial {sck, ce_n, reset_n} = 3'h3;
  // pins move only with the clock parked low, never mid-transfer
  task set(input logic s, r, input logic [3:0] v);
    @(negedge clk) {ce_n, reset_n, drive} = {!s, r, v};
    repeat (2) @(negedge clk);
  endtask : set
  task clock(input logic [3:0] v);
    drive = v;
    @(negedge clk) sck = 1;
    repeat (2) @(negedge clk);
    sck = 0;
    repeat (2) @(negedge clk);
  endtask : clock
endmodule : sfp_host

// ===== tb/tb.sv
/* bench for sfp_port; host model drives pins, checker binds itself */
`timescale 1ns/100ps
module tb;
  import sfp_pkg::*;
  logic clk = 0, reset = 1, core_drive = 0, sck, ce_n, reset_n;
  logic rx_valid, tx_take, in_reset, paused, selected;
  logic [3:0] core_tx = 4'h5, rx_bits, data_line_in, data_line_out, data_line_oe_n;
  sfp_cfg_t cfg = '0;
  int fails = 0, num_checks = 0, nv = 0, nt = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (rx_valid === 1'b1) nv <= nv + 1;
  always @(posedge clk) if (tx_take === 1'b1) nt <= nt + 1;
  sfp_port sfp_port_inst (.*);
  sfp_host sfp_host_inst (.*);
  task chk(input string n, input logic [3:0] s, e);
    num_checks++;
    if (s !== e) $display("wrong value %s exp %h seen %h", n, e, s);
    if (s !== e) fails++;
  endtask : chk
  task end_sim;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task t_rx;
    sfp_host_inst.set(1, 1, 4'hF);
    chk("selected", {3'h0, selected}, 4'h1);
    sfp_host_inst.clock(4'hF);
    chk("one lane", rx_bits, 4'h1);
    cfg = '{SFP_WIDTH_DUAL, 1'b1, 1'b0, 8'h00};
    sfp_host_inst.clock(4'h6);
    chk("two lanes", rx_bits, 4'h2);
    cfg.width = SFP_WIDTH_QUAD;
    sfp_host_inst.clock(4'hA);
    chk("four lanes", rx_bits, 4'hA);
  endtask : t_rx
  task t_tx;
    core_drive = 1;
    sfp_host_inst.clock(4'h0);
    chk("launch", data_line_out, 4'h5);
    chk("drive", data_line_oe_n, 4'h0);
    cfg.width = SFP_WIDTH_DUAL;
    sfp_host_inst.clock(4'h0);
    chk("two lane launch", data_line_out, 4'h1);
    chk("two lane drive", data_line_oe_n, 4'hC);
    cfg.width = SFP_WIDTH_SINGLE;
    sfp_host_inst.clock(4'h0);
    chk("one lane launch", data_line_out, 4'h2);
    chk("one lane drive", data_line_oe_n, 4'hD);
    chk("launches", nt[3:0], 4'h3);
  endtask : t_tx
  task t_off;
    core_drive = 0;
    sfp_host_inst.set(0, 1, 4'hF);
    sfp_host_inst.clock(4'h1);
    chk("deselect", {data_line_oe_n[3:1], nv == 3}, 4'hF);
    chk("deselected", {3'h0, selected}, 4'h0);
  endtask : t_off
  task t_rst;
    cfg = '{SFP_WIDTH_SINGLE, 1'b0, 1'b0, 8'h00};
    sfp_host_inst.set(1, 0, 4'hF);
    chk("rst", {in_reset, data_line_oe_n[2:0]}, 4'hF);
    cfg.func_cfg = 8'h01;
    sfp_host_inst.set(0, 0, 4'h7);
    chk("rst off", {3'h0, in_reset}, 4'h0);
    cfg.pause_or_reset_select_bit = 1;
    sfp_host_inst.set(0, 1, 4'h7);
    chk("rst pin", {3'h0, in_reset}, 4'h1);
    cfg.pause_or_reset_select_bit = 0;
    sfp_host_inst.set(1, 1, 4'h7);
    sfp_host_inst.clock(4'h7);
    chk("pause", {paused, nv == 3, data_line_oe_n[1:0]}, 4'hF);
  endtask : t_rst
  initial begin
    repeat (4) @(negedge clk);
    reset = 0;
    t_rx;
    t_tx;
    t_off;
    t_rst;
    end_sim;
  end
  initial begin
    #100000;
    fails++;
    end_sim;
  end
endmodule : tb
